/* File: rtl/tsr_core.sv */
// Registration control and protocol statistics for a network node.
// Assumes framing logic delivers one-cycle events and a register strobe.
// Notes on behaviour
// - Manual request needs pin transition plus free slot
// - Host unique id write triggers request
// - One request per trigger, no retry
// - Unhosted nodes report one fixed program id
// - Node configured by host write announces itself in slot
// - 24-bit frame counter at index 0xFB
// - Count sent or valid received frame starts
// - Frame counter wraps, accepts writes
// - Stats registers 0xC0 to 0xDF per slot
// - CRC count high half, missed low
// - Stats saturate, writes ignored
// - Bit 29 write clears stats at frame start
// - Master counts read slots, node write slots
// - CRC failure bumps slot CRC count
// - Missing preamble bumps missed slot count
// - Auto registration needs exact config bits
// - Free advert carries both zero id indices
// - Own id seen: load slot, configure, acknowledge
module tsr_core
    import tsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Installer pin
    input wire logic installer_trigger_pin_in,
    // Network events
    input wire tsr_net_t net_in,
    input wire logic [4:0] assigned_slot_in,
    // Register access
    input wire tsr_reg_t reg_in,
    // Outputs
    output logic [31:0] rdata_out,
    output logic reg_request_out,
    output logic [4:0] reg_request_slot_out,
    output logic announce_out,
    output logic assign_ack_out,
    output tsr_cfg_t cfg_out
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [TSR_SLOTS-1:0][2*TSR_CNT_W-1:0] stats;
        logic [TSR_FRAME_W-1:0] frame_start_count;
        logic clear_pending;
        tsr_cfg_t cfg;
        logic [63:0] program_type_id;
        logic [63:0] unique_node_id;
        logic pin_q;
        logic pin_ready;
        tsr_reg_state_t reg_state;
        logic announce_pending;
        logic [31:0] rdata;
        logic reg_request;
        logic [4:0] reg_request_slot;
        logic announce;
        logic assign_ack;
    } tsr_state_t;

    tsr_state_t st;
    tsr_state_t next_st;

    // Stats index helper used in read decode
    function automatic logic is_stats_idx(input logic [7:0] idx);
        return (idx >= TSR_IDX_STATS_FIRST) && (idx <= TSR_IDX_STATS_LAST);
    endfunction : is_stats_idx

    // ----------------------------------------
    // Config word layout
    // ----------------------------------------
    // Register word to fields; the gap at bit 5 is dropped on the way in
    function automatic tsr_cfg_t cfg_decode(input logic [31:0] w);
        tsr_cfg_t c;
        c.master_role_bit = w[TSR_CFG_MASTER_BIT];
        c.hosted_bit = w[TSR_CFG_HOSTED_BIT];
        c.auto_disc = w[TSR_CFG_AUTO_BIT];
        c.configured = w[TSR_CFG_DONE_BIT];
        c.pre_reg = w[TSR_CFG_PRE_BIT];
        c.slot_number_field = w[TSR_SLOT_W-1:0];
        return c;
    endfunction : cfg_decode

    // Fields back to the register word, unused bits read as zero
    function automatic logic [31:0] cfg_encode(input tsr_cfg_t c);
        logic [31:0] w;
        w = TSR_ZERO_WORD;
        w[TSR_CFG_MASTER_BIT] = c.master_role_bit;
        w[TSR_CFG_HOSTED_BIT] = c.hosted_bit;
        w[TSR_CFG_AUTO_BIT] = c.auto_disc;
        w[TSR_CFG_DONE_BIT] = c.configured;
        w[TSR_CFG_PRE_BIT] = c.pre_reg;
        w[TSR_SLOT_W-1:0] = c.slot_number_field;
        return w;
    endfunction : cfg_encode

    // Reset configuration in field form, so the reset branch stays constant
    localparam tsr_cfg_t TSR_CFG_RESET_FIELDS = cfg_decode({24'h000000, TSR_CFG_RESET});

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic trigger;
        logic count_slot;
        logic [4:0] sidx;
        logic [15:0] crc_c;
        logic [15:0] ms_c;
        trigger = 1'b0;
        count_slot = 1'b0;
        sidx = 5'h00;
        crc_c = 16'h0000;
        ms_c = 16'h0000;
        next_st = st;
        next_st.reg_request = 1'b0;
        next_st.announce = 1'b0;
        next_st.assign_ack = 1'b0;
        next_st.pin_q = installer_trigger_pin_in;
        next_st.pin_ready = 1'b1;

        // Any level change arms a request; first cycle after reset only samples
        if (st.pin_ready && installer_trigger_pin_in != st.pin_q) begin
            trigger = 1'b1;
        end

        // Register writes
        if (reg_in.wr) begin
            if (reg_in.idx == TSR_IDX_FRAME_COUNT) begin
                next_st.frame_start_count = reg_in.wdata[TSR_FRAME_W-1:0];
            end else if (reg_in.idx == TSR_IDX_UID_LO) begin
                next_st.unique_node_id[31:0] = reg_in.wdata;
                trigger = trigger | st.cfg.hosted_bit;
            end else if (reg_in.idx == TSR_IDX_UID_HI) begin
                next_st.unique_node_id[63:32] = reg_in.wdata;
                trigger = trigger | st.cfg.hosted_bit;
            end else if (reg_in.idx == TSR_IDX_PROGRAM_ID) begin
                // Only a hosted node may hold its own id
                if (st.cfg.hosted_bit) begin
                    next_st.program_type_id = {32'h00000000, reg_in.wdata};
                end
            end else if (reg_in.idx == TSR_IDX_CONFIG) begin
                next_st.cfg = cfg_decode(reg_in.wdata);
                // Going configured from the host path announces the node
                if (reg_in.wdata[TSR_CFG_DONE_BIT] && !st.cfg.configured) begin
                    next_st.announce_pending = 1'b1;
                end
            end else if (reg_in.idx == TSR_IDX_EVENT_STATUS) begin
                if (reg_in.wdata[TSR_EVT_CLEAR_STATS_BIT]) begin
                    next_st.clear_pending = 1'b1;
                end
            end
            // Stats writes fall through with no effect
        end

        // Unhosted nodes always show the fixed id
        if (!st.cfg.hosted_bit) begin
            next_st.program_type_id = TSR_UNHOSTED_PID;
        end

        // Register reads
        if (reg_in.rd) begin
            if (is_stats_idx(reg_in.idx)) begin
                next_st.rdata = st.stats[reg_in.idx[4:0]];
            end else if (reg_in.idx == TSR_IDX_FRAME_COUNT) begin
                next_st.rdata = {8'h00, st.frame_start_count};
            end else if (reg_in.idx == TSR_IDX_CONFIG) begin
                next_st.rdata = cfg_encode(st.cfg);
            end else if (reg_in.idx == TSR_IDX_PROGRAM_ID) begin
                next_st.rdata = st.program_type_id[31:0];
            end else if (reg_in.idx == TSR_IDX_UID_LO) begin
                next_st.rdata = st.unique_node_id[31:0];
            end else if (reg_in.idx == TSR_IDX_UID_HI) begin
                next_st.rdata = st.unique_node_id[63:32];
            end else if (reg_in.idx == TSR_IDX_REG_REQ) begin
                next_st.rdata = {29'h00000000, st.reg_state};
            end else begin
                next_st.rdata = TSR_ZERO_WORD;
            end
        end

        // Frame start: count, and apply a pending clear
        if (net_in.sof) begin
            next_st.frame_start_count = (st.frame_start_count == TSR_FRAME_MAX) ?
                '0 : st.frame_start_count + 24'h000001;
            if (st.clear_pending) begin
                next_st.stats = '0;
                next_st.clear_pending = 1'b0;
            end
        end

        // Slot statistics, role selects which slots count
        count_slot = net_in.slot_end && !net_in.sof &&
            (st.cfg.master_role_bit ? !net_in.slot_is_write : net_in.slot_is_write);
        if (count_slot) begin
            sidx = net_in.slot;
            crc_c = st.stats[sidx][2*TSR_CNT_W-1:TSR_STAT_CRC_LSB];
            ms_c = st.stats[sidx][TSR_CNT_W-1:0];
            if (net_in.crc_err && crc_c != TSR_CNT_MAX) begin
                crc_c = crc_c + 16'h0001;
            end
            if (!net_in.preamble_ok && ms_c != TSR_CNT_MAX) begin
                ms_c = ms_c + 16'h0001;
            end
            next_st.stats[sidx] = {crc_c, ms_c};
        end

        // Own id assigned in a slot: load slot, configure, then ack
        if (net_in.uid_match && !st.cfg.master_role_bit) begin
            next_st.cfg.slot_number_field = net_in.slot;
            next_st.cfg.configured = 1'b1;
            next_st.assign_ack = 1'b1;
            next_st.reg_state = TSR_IDLE;
        end

        // Announce in own slot once configured
        if (st.announce_pending && st.cfg.configured && net_in.slot_end &&
            net_in.slot == st.cfg.slot_number_field) begin
            next_st.announce = 1'b1;
            next_st.announce_pending = 1'b0;
        end

        // Registration request machine
        case (st.reg_state)
            TSR_IDLE: begin
                // Auto mode arms at once; manual mode waits for a trigger
                if (!st.cfg.master_role_bit && !st.cfg.configured) begin
                    if (!st.cfg.hosted_bit && st.cfg.auto_disc && st.cfg.pre_reg) begin
                        next_st.reg_state = TSR_ARMED;
                    end else if (trigger && !st.cfg.auto_disc) begin
                        next_st.reg_state = TSR_ARMED;
                    end
                end
            end
            TSR_ARMED: begin
                // Free advert must carry both zero id words
                if (net_in.free_adv) begin
                    next_st.reg_request = 1'b1;
                    next_st.reg_request_slot = net_in.slot;
                    next_st.reg_state = TSR_WAIT;
                end
            end
            TSR_WAIT: begin
                // No self retry: a fresh trigger is needed
                if (trigger && !st.cfg.configured && !st.cfg.auto_disc) begin
                    next_st.reg_state = TSR_ARMED;
                end
            end
            default: begin
                next_st.reg_state = TSR_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st <= '0;
            st.cfg <= TSR_CFG_RESET_FIELDS;
            st.reg_state <= TSR_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata_out = st.rdata;
    assign reg_request_out = st.reg_request;
    assign reg_request_slot_out = st.reg_request_slot;
    assign announce_out = st.announce;
    assign assign_ack_out = st.assign_ack;
    assign cfg_out = st.cfg;

    // assigned_slot_in is reserved for a future hardwired strap path
    logic unused_slot;
    assign unused_slot = ^assigned_slot_in;
endmodule : tsr_core

/* File: common/tsr_pkg.sv */
// Package for the timeslot registration and statistics block.
// Assumes one system clock; register access is by protocol index.
package tsr_pkg;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int TSR_SLOTS = 32;
    localparam int TSR_SLOT_W = 5;
    localparam int TSR_IDX_W = 8;
    localparam int TSR_FRAME_W = 24;
    localparam int TSR_CNT_W = 16;

    // ----------------------------------------
    // Protocol indices
    // ----------------------------------------
    localparam logic [7:0] TSR_IDX_STATS_FIRST = 8'hc0;
    localparam logic [7:0] TSR_IDX_STATS_LAST = 8'hdf;
    localparam logic [7:0] TSR_IDX_FRAME_COUNT = 8'hfb;
    localparam logic [7:0] TSR_IDX_UID_LO = 8'hfd;
    localparam logic [7:0] TSR_IDX_UID_HI = 8'hfe;
    localparam logic [7:0] TSR_IDX_PROGRAM_ID = 8'hf0;
    localparam logic [7:0] TSR_IDX_CONFIG = 8'hf1;
    localparam logic [7:0] TSR_IDX_EVENT_STATUS = 8'hf2;
    localparam logic [7:0] TSR_IDX_REG_REQ = 8'hf3;

    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    localparam int TSR_STAT_CRC_LSB = 16;
    localparam int TSR_EVT_CLEAR_STATS_BIT = 29;
    localparam int TSR_CFG_MASTER_BIT = 10;
    localparam int TSR_CFG_HOSTED_BIT = 9;
    localparam int TSR_CFG_AUTO_BIT = 8;
    localparam int TSR_CFG_DONE_BIT = 7;
    localparam int TSR_CFG_PRE_BIT = 6;
    localparam logic [15:0] TSR_CNT_MAX = 16'hffff;
    localparam logic [23:0] TSR_FRAME_MAX = 24'hffffff;
    localparam logic [31:0] TSR_ZERO_WORD = 32'h00000000;
    // Unhosted program id; value arbitrary
    localparam logic [63:0] TSR_UNHOSTED_PID = 64'h0000000000000000;
    localparam logic [7:0] TSR_CFG_RESET = 8'h40;

    // Configuration fields
    typedef struct packed {
        logic master_role_bit;
        logic hosted_bit;
        logic auto_disc;
        logic configured;
        logic pre_reg;
        logic [4:0] slot_number_field;
    } tsr_cfg_t;

    // Network events from the framing logic
    typedef struct packed {
        logic sof;
        logic slot_end;
        logic slot_is_write;
        logic [4:0] slot;
        logic crc_err;
        logic preamble_ok;
        logic free_adv;
        logic uid_match;
    } tsr_net_t;

    // Register access strobe
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] idx;
        logic [31:0] wdata;
    } tsr_reg_t;

    typedef enum logic [2:0] {
        TSR_IDLE = 3'b001,
        TSR_ARMED = 3'b010,
        TSR_WAIT = 3'b100
    } tsr_reg_state_t;
endpackage : tsr_pkg

/* File: test/tsr_core_props.sv */
// Checker for the registration and statistics outputs.
// Assumes a bind onto tsr_core; one clock, async high reset.
module tsr_core_chk
    import tsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Inputs of the block
    input wire logic installer_trigger_pin_in,
    input wire tsr_net_t net_in,
    input wire logic [4:0] assigned_slot_in,
    input wire tsr_reg_t reg_in,
    // Outputs of the block
    input wire logic [31:0] rdata_out,
    input wire logic reg_request_out,
    input wire logic [4:0] reg_request_slot_out,
    input wire logic announce_out,
    input wire logic assign_ack_out,
    input wire tsr_cfg_t cfg_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    // Requests only follow an offer, on the offered slot
    chk_req_cause: assert property (
        reg_request_out |-> $past(net_in.free_adv) && reg_request_slot_out == $past(net_in.slot))
        else $error("request without offer");
    chk_req_single: assert property (
        reg_request_out |=> !reg_request_out) else $error("request longer than one cycle");
    // Without a fresh trigger no second request may come three cycles after the first
    chk_no_retry: assert property (
        (reg_request_out && $stable(installer_trigger_pin_in) && !reg_in.wr)
        ##1 ($stable(installer_trigger_pin_in) && !reg_in.wr)[*3] |-> !reg_request_out)
        else $error("request repeated without trigger");
    chk_conf_quiet: assert property (
        $past(cfg_out.configured) |-> !reg_request_out) else $error("request while configured");
    chk_ack_cause: assert property (
        assign_ack_out |-> $past(net_in.uid_match) && cfg_out.configured)
        else $error("acknowledge without own id");
    chk_assign_load: assert property (
        net_in.uid_match && !cfg_out.configured && !cfg_out.master_role_bit
        |=> assign_ack_out && cfg_out.slot_number_field == $past(net_in.slot))
        else $error("assignment not taken");
    chk_frame_upper: assert property (
        reg_in.rd && reg_in.idx == TSR_IDX_FRAME_COUNT |=> rdata_out[31:24] == 8'h00)
        else $error("frame count upper byte set");
    chk_announce_slot: assert property (
        announce_out |-> $past(net_in.slot_end) && cfg_out.configured
        && $past(net_in.slot) == cfg_out.slot_number_field) else $error("announce off slot");
endmodule : tsr_core_chk

bind tsr_core tsr_core_chk u_chk (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .installer_trigger_pin_in(installer_trigger_pin_in), .net_in(net_in),
    .assigned_slot_in(assigned_slot_in), .reg_in(reg_in), .rdata_out(rdata_out),
    .reg_request_out(reg_request_out), .reg_request_slot_out(reg_request_slot_out),
    .announce_out(announce_out), .assign_ack_out(assign_ack_out), .cfg_out(cfg_out));

/* File: test/tsr_net_model.sv */
// Network master model: drives framing events into the block.
// Assumes put() is called at a falling clock edge.
module tsr_net_model
    import tsr_pkg::*;
(
    // Clock
    input wire logic clk_sys_in,
    // Events toward the block
    output tsr_net_t net_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] reserved = 32'h0;
    initial net_out = '0;
    // Hardwired slots are booked without any network traffic
    task automatic reserve(input logic [4:0] s);
        reserved[s] = 1'b1;
    endtask : reserve
    // Event held n cycles; slot lines scrambled after, never left stale
    task automatic put(input tsr_net_t e, input int n);
        if (reserved[e.slot]) begin
            e.free_adv = 1'b0;
        end
        net_out = e;
        repeat (n) @(negedge clk_sys_in);
        net_out = tsr_net_t'({3'h0, ~e.slot, 4'h0});
        @(negedge clk_sys_in);
    endtask : put
endmodule : tsr_net_model

/* File: test/test_tsr_core.sv */
// Self-checking bench for tsr_core with a network master model.
// Assumes inputs change at falling edges; monitor compares queued notes.
module test_tsr_core;
    import tsr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam tsr_net_t EV_SOF = 12'h800;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in;
    logic pin = 1'b0;
    tsr_net_t net;
    tsr_reg_t reg_q = '0;
    logic [31:0] rdata;
    logic req, ann, ack, rd_seen = 1'b0;
    logic [4:0] req_slot;
    tsr_cfg_t cfg;
    logic [31:0] q_rd[$];
    logic [11:0] q_evt[$];
    logic [11:0] ev_seen, ev_exp;
    logic [31:0] v;
    int fail_count = 0, checks_done = 0, cycles = 0, k;

    always #10 clk_sys_in = ~clk_sys_in;

    tsr_core u_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .installer_trigger_pin_in(pin), .net_in(net), .assigned_slot_in(5'h00),
        .reg_in(reg_q), .rdata_out(rdata), .reg_request_out(req),
        .reg_request_slot_out(req_slot), .announce_out(ann), .assign_ack_out(ack), .cfg_out(cfg));
    tsr_net_model u_net (.clk_sys_in(clk_sys_in), .net_out(net));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic rst();
        sys_rst_in = 1'b1;
        repeat (5) @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        @(negedge clk_sys_in);
    endtask : rst

    // One register access; a read notes d as the expected answer
    task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] d);
        reg_q = {w, ~w, idx, d};
        if (!w) q_rd.push_back(d);
        @(negedge clk_sys_in);
        reg_q = '0;
        @(negedge clk_sys_in);
    endtask : acc

    function automatic tsr_net_t nev(input logic [2:0] a, input logic [4:0] s, input logic [3:0] b);
        return {a, s, b};
    endfunction : nev

    always @(posedge clk_sys_in) begin
        rd_seen <= reg_q.rd;
    end

    // Outputs compared to the oldest note; an unexpected pulse fails
    always @(negedge clk_sys_in) begin
        cycles++;
        if (cycles > 80000) begin
            fail_count++;
            summarize();
        end else begin
            if (rd_seen) check(rdata, q_rd.size() ? q_rd.pop_front() : ~rdata);
            ev_seen = req ? {2'd1, 5'd0, req_slot} : ack ? {2'd2, cfg} : {2'd3, 10'h000};
            if (req | ack | ann) begin
                ev_exp = q_evt.size() ? q_evt.pop_front() : ~ev_seen;
                check(32'(ev_seen), 32'(ev_exp));
            end
        end
    end

    initial begin
        void'($urandom(32'h984818fa));
        rst();
        check(32'(cfg), 32'({5'b00001, 5'd0}));
        acc(0, TSR_IDX_CONFIG, 32'h00000040);
        acc(0, TSR_IDX_FRAME_COUNT, 32'h0);
        v = $urandom();
        acc(1, TSR_IDX_FRAME_COUNT, {v[31:24], 24'hfffffe});
        u_net.put(EV_SOF, 1);
        acc(0, TSR_IDX_FRAME_COUNT, 32'h00ffffff);
        u_net.put(EV_SOF, 1);
        acc(0, TSR_IDX_FRAME_COUNT, 32'h0);
        acc(1, TSR_IDX_FRAME_COUNT, v);
        u_net.put(EV_SOF, 1);
        acc(0, TSR_IDX_FRAME_COUNT, {8'h00, v[23:0] + 24'h1});
        $display("frame count test done");
        k = $urandom_range(4, 1);
        u_net.put(nev(3'b011, 5'd3, 4'b1100), k);
        u_net.put(nev(3'b010, 5'd3, 4'b1100), 1);
        u_net.put(nev(3'b011, 5'd31, 4'b0000), 1);
        acc(1, 8'hc3, $urandom());
        acc(0, 8'hc3, {16'(k), 16'h0});
        acc(0, TSR_IDX_STATS_LAST, 32'h1);
        acc(1, TSR_IDX_EVENT_STATUS, 32'h20000000);
        acc(0, 8'hc3, {16'(k), 16'h0});
        u_net.put(EV_SOF, 1);
        acc(0, 8'hc3, 32'h0);
        u_net.put(nev(3'b011, 5'd0, 4'b1000), 65540);
        acc(0, TSR_IDX_STATS_FIRST, 32'hffffffff);
        $display("statistics test done");
        rst();
        acc(1, TSR_IDX_CONFIG, 32'h0);
        pin = ~pin;
        repeat (2) @(negedge clk_sys_in);
        q_evt.push_back({2'd1, 5'd0, 5'd5});
        u_net.put(nev(3'b000, 5'd5, 4'b0010), 1);
        u_net.put(nev(3'b000, 5'd6, 4'b0010), 1);
        q_evt.push_back({2'd2, 5'b00010, 5'd7});
        u_net.put(nev(3'b000, 5'd7, 4'b0001), 1);
        $display("manual registration test done");
        rst();
        u_net.reserve(5'd9);
        acc(1, TSR_IDX_PROGRAM_ID, $urandom());
        acc(0, TSR_IDX_PROGRAM_ID, TSR_UNHOSTED_PID[31:0]);
        acc(1, TSR_IDX_CONFIG, 32'h00000009);
        acc(1, TSR_IDX_CONFIG, 32'h00000089);
        check(32'(cfg), 32'({5'b00010, 5'd9}));
        acc(0, TSR_IDX_CONFIG, 32'h00000089);
        q_evt.push_back({2'd3, 10'h000});
        u_net.put(nev(3'b011, 5'd9, 4'b0100), 1);
        acc(1, TSR_IDX_UID_LO, $urandom());
        $display("hardwired test done");
        rst();
        acc(1, TSR_IDX_CONFIG, 32'h00000200);
        acc(1, TSR_IDX_UID_LO, $urandom());
        acc(1, TSR_IDX_UID_HI, $urandom());
        u_net.put(nev(3'b000, 5'd9, 4'b0010), 1);
        q_evt.push_back({2'd1, 5'd0, 5'd2});
        u_net.put(nev(3'b000, 5'd2, 4'b0010), 1);
        repeat (4) @(negedge clk_sys_in);
        check(32'(q_rd.size() + q_evt.size()), 32'h0);
        $display("hosted test done");
        rst();
        acc(1, TSR_IDX_CONFIG, 32'h00000140);
        q_evt.push_back({2'd1, 5'd0, 5'd4});
        u_net.put(nev(3'b000, 5'd4, 4'b0010), 1);
        acc(1, TSR_IDX_CONFIG, 32'h00000400);
        u_net.put(nev(3'b010, 5'd1, 4'b1100), 1);
        u_net.put(nev(3'b011, 5'd1, 4'b1100), 1);
        acc(0, 8'hc1, 32'h00010000);
        repeat (4) @(negedge clk_sys_in);
        check(32'(q_rd.size() + q_evt.size()), 32'h0);
        $display("auto and master test done");
        summarize();
    end
endmodule : test_tsr_core
